/* File: rtl/gamcid_regs.sv */
// register bank for pin alternate modes and chip identification
`timescale 1ns/1ps
`default_nettype none
module gamcid_regs #(
  parameter logic [23:0] SERIAL_DEFAULT = 24'h5a3c96,
  // arbitrary value
  parameter logic [3:0] METAL_DEFAULT = 4'ha,
  // arbitrary value
  parameter logic [3:0] GRADE_DEFAULT = 4'h5,
  parameter logic [7:0] OTP_TAG_DEFAULT = 8'h6e
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // alternate sources
  input wire logic [7:0] power_sequencer,
  input wire logic slow_clock_output,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  // supply good from pin 3
  output logic ext_supply_good
);

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_core_n;
  gamcid_pkg::gamcid_req_s req;
  logic [23:0] serial_number_field_q;
  logic [3:0] metal_revision_field_q;
  logic [3:0] device_grade_field_q;
  logic [7:0] otp_config_tag_field_q;
  logic [7:0] alt_mode_select_bit_q;
  logic [7:0] dir_ctrl_q;
  logic [7:0] out_level_q;
  logic [7:0] in_level_q;
  logic [7:0] rdata_d;
  logic id_load_q;
  gamcid_pkg::gamcid_pin_s drive;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_core_n = rst_sync2_q;

  assign req.wr = reg_wr;
  assign req.rd = reg_rd;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;

  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      serial_number_field_q <= SERIAL_DEFAULT;
      metal_revision_field_q <= METAL_DEFAULT;
      device_grade_field_q <= GRADE_DEFAULT;
      otp_config_tag_field_q <= OTP_TAG_DEFAULT;
    end else if (req.wr) begin
      unique case (req.addr)
        gamcid_pkg::ADDR_SERIAL_LOW: serial_number_field_q[7:0] <= req.wdata;
        gamcid_pkg::ADDR_SERIAL_MID: serial_number_field_q[15:8] <= req.wdata;
        gamcid_pkg::ADDR_SERIAL_HIGH: serial_number_field_q[23:16] <= req.wdata;
        gamcid_pkg::ADDR_REV_GRADE: begin
          metal_revision_field_q <= req.wdata[gamcid_pkg::METAL_MSB:gamcid_pkg::METAL_LSB];
          device_grade_field_q <= req.wdata[gamcid_pkg::GRADE_MSB:gamcid_pkg::GRADE_LSB];
        end
        gamcid_pkg::ADDR_OTP_TAG: otp_config_tag_field_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // marks the first cycle after reset release
  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      id_load_q <= 1'b1;
    end else begin
      id_load_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      alt_mode_select_bit_q <= gamcid_pkg::ALT_MODE_RESET;
      dir_ctrl_q <= gamcid_pkg::DIR_CTRL_RESET;
      out_level_q <= gamcid_pkg::OUT_LEVEL_RESET;
    end else if (req.wr) begin
      if (req.addr == gamcid_pkg::ADDR_ALT_MODE) begin
        alt_mode_select_bit_q <= req.wdata;
      end
      if (req.addr == gamcid_pkg::ADDR_DIR_CTRL) begin
        dir_ctrl_q <= req.wdata;
      end
      if (req.addr == gamcid_pkg::ADDR_OUT_LEVEL) begin
        out_level_q <= req.wdata;
      end
    end
  end

  // pin sample
  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      in_level_q <= gamcid_pkg::PIN_IDLE;
    end else begin
      in_level_q <= pin_in;
    end
  end

  // read decode
  always_comb begin
    rdata_d = gamcid_pkg::RDATA_IDLE;
    if (req.rd) begin
      unique case (req.addr)
        gamcid_pkg::ADDR_SERIAL_LOW: rdata_d = serial_number_field_q[7:0];
        gamcid_pkg::ADDR_SERIAL_MID: rdata_d = serial_number_field_q[15:8];
        gamcid_pkg::ADDR_SERIAL_HIGH: rdata_d = serial_number_field_q[23:16];
        gamcid_pkg::ADDR_REV_GRADE: rdata_d = {metal_revision_field_q, device_grade_field_q};
        gamcid_pkg::ADDR_OTP_TAG: rdata_d = otp_config_tag_field_q;
        gamcid_pkg::ADDR_ALT_MODE: rdata_d = alt_mode_select_bit_q;
        gamcid_pkg::ADDR_DIR_CTRL: rdata_d = dir_ctrl_q;
        gamcid_pkg::ADDR_OUT_LEVEL: rdata_d = out_level_q;
        gamcid_pkg::ADDR_IN_LEVEL: rdata_d = in_level_q;
        default: rdata_d = gamcid_pkg::RDATA_IDLE;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      reg_rdata <= gamcid_pkg::RDATA_IDLE;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  gamcid_pin_mux u_pin_mux (
    .alt_mode_select_bit(alt_mode_select_bit_q),
    .pin_direction_bit_a(dir_ctrl_q[gamcid_pkg::DIR_A_POS]),
    .pin_direction_bit_b(dir_ctrl_q[gamcid_pkg::DIR_B_POS]),
    .gp_out_level(out_level_q),
    .power_sequencer(power_sequencer),
    .slow_clock_output(slow_clock_output),
    .drive(drive)
  );

  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pin_out <= gamcid_pkg::PIN_IDLE;
      pin_oe_n <= gamcid_pkg::OE_N_IDLE;
    end else begin
      pin_out <= drive.out;
      pin_oe_n <= drive.oe_n;
    end
  end

  // supply good taken from pin 3
  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ext_supply_good <= 1'b0;
    end else begin
      ext_supply_good <= alt_mode_select_bit_q[gamcid_pkg::SUPPLY_PIN]
                         & in_level_q[gamcid_pkg::SUPPLY_PIN];
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_core_n);

  seq_pin_drive_a: assert property (
    alt_mode_select_bit_q[0] |=> !pin_oe_n[0] && pin_out[0] == $past(power_sequencer[0]))
    else $error("pin 0 not driven by sequencer");

  seq_pin2_drive_a: assert property (
    alt_mode_select_bit_q[2] |=> !pin_oe_n[2] && pin_out[2] == $past(power_sequencer[2]))
    else $error("pin 2 not driven by sequencer");

  supply_pin_input_a: assert property (
    alt_mode_select_bit_q[3] && in_level_q[3] |=> pin_oe_n[3] && ext_supply_good)
    else $error("pin 3 not used as supply good input");

  supply_off_a: assert property (
    !alt_mode_select_bit_q[3] |=> !ext_supply_good)
    else $error("supply good raised while pin 3 is gpio");

  clock_pin_out_a: assert property (
    alt_mode_select_bit_q[5] |=> !pin_oe_n[5] && pin_out[5] == $past(slow_clock_output))
    else $error("pin 5 not carrying slow clock");

  gpio_dir_a: assert property (
    !alt_mode_select_bit_q[4] |=> pin_oe_n[4] == !$past(dir_ctrl_q[1]))
    else $error("pin 4 direction not from its control bit");

  gpio_level_a: assert property (
    !alt_mode_select_bit_q[1] && dir_ctrl_q[0] |=> pin_out[1] == $past(out_level_q[1]))
    else $error("pin 1 gpio level wrong");

  pin7_mode_a: assert property (
    alt_mode_select_bit_q[7] |=> !pin_oe_n[7] && pin_out[7] == $past(power_sequencer[7]))
    else $error("pin 7 not driven by sequencer");

  pin7_gpio_a: assert property (
    !alt_mode_select_bit_q[7] |=> pin_oe_n[7] == !$past(dir_ctrl_q[0]))
    else $error("pin 7 gpio direction wrong");

  serial_read_a: assert property (
    reg_rd && reg_addr == gamcid_pkg::ADDR_SERIAL_HIGH
      |=> reg_rdata == $past(serial_number_field_q[23:16]))
    else $error("serial high byte read wrong");

  serial_write_a: assert property (
    reg_wr && reg_addr == gamcid_pkg::ADDR_SERIAL_MID
      ##2 reg_rd && reg_addr == gamcid_pkg::ADDR_SERIAL_MID
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("serial mid byte not stored");

  metal_field_a: assert property (
    reg_rd && reg_addr == gamcid_pkg::ADDR_REV_GRADE
      |=> reg_rdata[7:4] == $past(metal_revision_field_q))
    else $error("metal revision field misplaced");

  grade_field_a: assert property (
    reg_rd && reg_addr == gamcid_pkg::ADDR_REV_GRADE
      |=> reg_rdata[3:0] == $past(device_grade_field_q))
    else $error("device grade field misplaced");

  otp_tag_a: assert property (
    id_load_q |-> otp_config_tag_field_q == OTP_TAG_DEFAULT)
    else $error("otp tag not loaded at reset");

  alt_timing_a: assert property (
    reg_wr && reg_addr == gamcid_pkg::ADDR_ALT_MODE && reg_wdata[6] ##1 1'b1
      |=> !pin_oe_n[6] && pin_out[6] == $past(slow_clock_output))
    else $error("alt mode change late on pin 6");

  idle_read_a: assert property (
    !reg_rd |=> reg_rdata == gamcid_pkg::RDATA_IDLE)
    else $error("read data outside read slot");

  alt_write_c: cover property (reg_wr && reg_addr == gamcid_pkg::ADDR_ALT_MODE ##2 !pin_oe_n[0]);
  serial_read_c: cover property (reg_rd && reg_addr == gamcid_pkg::ADDR_SERIAL_LOW
    ##2 reg_rd && reg_addr == gamcid_pkg::ADDR_SERIAL_MID);
  supply_good_c: cover property (ext_supply_good);
  gpio_out_c: cover property (!alt_mode_select_bit_q[4] && !pin_oe_n[4]);

endmodule
`default_nettype wire

/* File: rtl/gamcid_pkg.sv */
// constants, types and register map of the pin mode and chip id register bank
package gamcid_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PIN_N = 8;

  // register offsets
  localparam logic [7:0] ADDR_SERIAL_LOW = 8'hb0;
  localparam logic [7:0] ADDR_SERIAL_MID = 8'hb1;
  localparam logic [7:0] ADDR_SERIAL_HIGH = 8'hb2;
  localparam logic [7:0] ADDR_REV_GRADE = 8'hb3;
  localparam logic [7:0] ADDR_OTP_TAG = 8'hb4;
  localparam logic [7:0] ADDR_ALT_MODE = 8'h7a;
  localparam logic [7:0] ADDR_DIR_CTRL = 8'h7b;
  localparam logic [7:0] ADDR_OUT_LEVEL = 8'h7c;
  localparam logic [7:0] ADDR_IN_LEVEL = 8'h7d;

  // reset values of the pin control registers and of the read data and pin flops
  localparam logic [7:0] ALT_MODE_RESET = 8'h00;
  localparam logic [7:0] DIR_CTRL_RESET = 8'h00;
  localparam logic [7:0] OUT_LEVEL_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam logic [7:0] PIN_IDLE = 8'h00;
  localparam logic [7:0] OE_N_IDLE = 8'hff;

  // field positions
  localparam int unsigned DIR_A_POS = 0;
  localparam int unsigned DIR_B_POS = 1;
  localparam int unsigned METAL_MSB = 7;
  localparam int unsigned METAL_LSB = 4;
  localparam int unsigned GRADE_MSB = 3;
  localparam int unsigned GRADE_LSB = 0;
  localparam int unsigned SUPPLY_PIN = 3;

  // pin groups
  localparam logic [7:0] SEQ_PIN_MASK = 8'h87;
  localparam logic [7:0] CLK_PIN_MASK = 8'h70;
  localparam logic [7:0] SUPPLY_PIN_MASK = 8'h08;
  localparam logic [7:0] DIR_B_PIN_MASK = 8'h78;

  typedef enum logic [1:0] {
    gamcid_mode_gpio,
    gamcid_mode_seq,
    gamcid_mode_supply,
    gamcid_mode_clk
  } gamcid_pin_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gamcid_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } gamcid_pin_s;

endpackage

/* File: rtl/gamcid_pin_mux.sv */
// per pin routing between general purpose logic and the alternate functions
`timescale 1ns/1ps
`default_nettype none
module gamcid_pin_mux (
  // controls
  input wire logic [7:0] alt_mode_select_bit,
  input wire logic pin_direction_bit_a,
  input wire logic pin_direction_bit_b,
  input wire logic [7:0] gp_out_level,
  // alternate sources
  input wire logic [7:0] power_sequencer,
  input wire logic slow_clock_output,
  // routed drive
  output gamcid_pkg::gamcid_pin_s drive
);

  for (genvar i = 0; i < gamcid_pkg::PIN_N; i++) begin : g_pin
    gamcid_pkg::gamcid_pin_mode_e mode;
    logic dir;
    always_comb begin
      dir = gamcid_pkg::DIR_B_PIN_MASK[i] ? pin_direction_bit_b : pin_direction_bit_a;
      if (!alt_mode_select_bit[i]) begin
        mode = gamcid_pkg::gamcid_mode_gpio;
      end else if (gamcid_pkg::SEQ_PIN_MASK[i]) begin
        mode = gamcid_pkg::gamcid_mode_seq;
      end else if (gamcid_pkg::SUPPLY_PIN_MASK[i]) begin
        mode = gamcid_pkg::gamcid_mode_supply;
      end else begin
        mode = gamcid_pkg::gamcid_mode_clk;
      end
      unique case (mode)
        gamcid_pkg::gamcid_mode_gpio: begin
          drive.out[i] = dir & gp_out_level[i];
          drive.oe_n[i] = ~dir;
        end
        gamcid_pkg::gamcid_mode_seq: begin
          drive.out[i] = power_sequencer[i];
          drive.oe_n[i] = 1'b0;
        end
        gamcid_pkg::gamcid_mode_supply: begin
          drive.out[i] = 1'b0;
          drive.oe_n[i] = 1'b1;
        end
        gamcid_pkg::gamcid_mode_clk: begin
          drive.out[i] = slow_clock_output;
          drive.oe_n[i] = 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: bench/gamcid_host.sv */
// host model that reaches the pin mode and id registers over the register port
`timescale 1ns/1ps
`default_nettype none
module gamcid_host (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one cycle write; address and data turn to junk once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one cycle read; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: bench/gamcid_regs_tb.sv */
// self-checking bench for the pin mode and id register bank
`timescale 1ns/1ps
`default_nettype none
module gamcid_regs_tb;
  logic sys_clk = 1'b0;
  logic rst_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ps, pin, pin_out, pin_oe_n;
  logic reg_wr, reg_rd, sc, ext_supply_good;
  logic [7:0] alt, dir, lvl, d, v;
  logic [7:0] mdl [0:255];
  int mismatches = 0;
  int n_tests = 0;

  always #50 sys_clk = ~sys_clk;

  gamcid_host gamcid_host_inst (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // id defaults are arbitrary values
  gamcid_regs #(.SERIAL_DEFAULT(24'hc4d2e1), .METAL_DEFAULT(4'h9), .GRADE_DEFAULT(4'h6),
    .OTP_TAG_DEFAULT(8'h3b)) gamcid_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_sequencer(ps), .slow_clock_output(sc), .pin_in(pin),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_supply_good(ext_supply_good));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic rchk(input logic [7:0] a);
    logic [7:0] r;
    gamcid_host_inst.rd(a, r);
    chk(r, mdl[a]);
  endtask

  // expected routing worked out per pin from the mode rules
  task automatic pin_chk;
    logic [7:0] eo;
    logic [7:0] eoe;
    logic dr;
    eo = 8'h00;
    eoe = 8'hff;
    for (int i = 0; i < 8; i++) begin
      dr = (i >= 3 && i <= 6) ? dir[1] : dir[0];
      if (alt[i] && i != 3) begin
        eo[i] = (i >= 4 && i <= 6) ? sc : ps[i];
        eoe[i] = 1'b0;
      end else if (!alt[i] && dr) begin
        eo[i] = lvl[i];
        eoe[i] = 1'b0;
      end
    end
    chk(pin_out, eo);
    chk(pin_oe_n, eoe);
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize;
  end

  initial begin
    void'($urandom(3));
    rst_n = 1'b0;
    ps = 8'h00;
    sc = 1'b0;
    pin = 8'h00;
    alt = 8'h00;
    dir = 8'h00;
    lvl = 8'h00;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'hb0] = 8'he1;
    mdl[8'hb1] = 8'hd2;
    mdl[8'hb2] = 8'hc4;
    mdl[8'hb3] = 8'h96;
    mdl[8'hb4] = 8'h3b;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    pin_chk;
    chk({7'h00, ext_supply_good}, 8'h00);
    for (int a = 'hb0; a <= 'hb4; a++) rchk(8'(a));
    rchk(8'h7a);
    rchk(8'h7b);
    rchk(8'h7c);
    rchk(8'h55);
    // id registers take any value, reserved codes included
    for (int a = 'hb0; a <= 'hb4; a++) begin
      v = 8'($urandom);
      gamcid_host_inst.wr(8'(a), v);
      mdl[a] = v;
    end
    for (int a = 'hb0; a <= 'hb4; a++) rchk(8'(a));
    // write then read back the middle serial byte
    v = 8'($urandom);
    gamcid_host_inst.wr(8'hb1, v);
    mdl[8'hb1] = v;
    rchk(8'hb1);
    // unmapped and read-only places ignore writes
    gamcid_host_inst.wr(8'h55, 8'ha5);
    gamcid_host_inst.wr(8'h7d, 8'h3c);
    rchk(8'h55);
    rchk(8'h7d);
    gamcid_host_inst.rd(8'hb4, d);
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 8'h00);
    // mode sweep: all set, all clear, then random mixes
    for (int k = 0; k < 24; k++) begin
      @(posedge sys_clk);
      ps <= 8'($urandom);
      sc <= 1'($urandom);
      pin <= 8'($urandom);
      dir = 8'($urandom) & 8'h03;
      lvl = 8'($urandom);
      alt = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
      gamcid_host_inst.wr(8'h7b, dir);
      gamcid_host_inst.wr(8'h7c, lvl);
      gamcid_host_inst.wr(8'h7a, alt);
      @(posedge sys_clk);
      #1;
      pin_chk;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({7'h00, ext_supply_good}, {7'h00, alt[3] & pin[3]});
      mdl[8'h7a] = alt;
      mdl[8'h7b] = dir;
      mdl[8'h7c] = lvl;
      mdl[8'h7d] = pin;
      rchk(8'h7a);
      rchk(8'h7b);
      rchk(8'h7c);
      rchk(8'h7d);
    end
    summarize;
  end
endmodule
`default_nettype wire
